// ==== hdl/dscr_map.vh ====
// register offsets, field positions, reset values and timing counts
// assumes: included by the register bank and its parity monitor
`ifndef DSCR_MAP_VH
`define DSCR_MAP_VH
`define DSCR_ADDR_RESET 8'h01
`define DSCR_ADDR_GENCFG 8'h02
`define DSCR_ADDR_VERSION 8'h03
`define DSCR_ADDR_DEVCOND 8'h04
`define DSCR_ADDR_PAR_UP 8'h05
`define DSCR_ADDR_PAR_LO 8'h06
`define DSCR_ADDR_CCTO 8'h07
`define DSCR_ADDR_BUSCTL1 8'h08
`define DSCR_BIT_RELOAD 2
`define DSCR_BIT_PAR_EN 1
`define DSCR_BIT_CKSUM 7
`define DSCR_BIT_INIT 6
`define DSCR_BIT_PASS 3
`define DSCR_BIT_LOCK 2
`define DSCR_BIT_CCTO_OFF 0
`define DSCR_BIT_RWR_BLOCK 7
`define DSCR_RST_GENCFG 8'h1E
`define DSCR_RST_PAR_UP 8'h01
`define DSCR_RST_PAR_LO 8'h00
`define DSCR_RST_CCTO 8'hFE
`define DSCR_RST_BUSCTL1 8'h00
// version value is arbitrary
`define DSCR_VERSION_VAL 8'h50
`define DSCR_TICK_MS 2
`define DSCR_CLK_KHZ 200000
`define DSCR_TICK_CYC (`DSCR_TICK_MS * `DSCR_CLK_KHZ)
`endif

// ==== hdl/dscr_parity_mon.v ====
// per-port parity error counter with sticky limit flag
// assumes: parity_err is a one-cycle pulse per detected error
`timescale 1ns/1ps
`include "dscr_map.vh"
module dscr_parity_mon
(
    input wire clk,
    input wire rst,
    input wire enable,
    input wire parity_err,
    input wire [15:0] limit,
    input wire flag_clear,
    output reg limit_hit_q
);
reg [15:0] count_q;
wire hit_d;
// counter saturates so a long burst never wraps below the limit
assign hit_d = enable && (count_q >= limit);
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        count_q <= 16'h0000;
        limit_hit_q <= 1'b0;
    end
    else
    begin
        // (RL15) counter clears when disabled
        if (!enable)
            count_q <= 16'h0000;
        else if (parity_err && count_q != 16'hFFFF)
            count_q <= count_q + 16'h0001;
        // (RL7) flag at threshold reached
        if (hit_d)
            limit_hit_q <= 1'b1;
        else if (flag_clear)
            limit_hit_q <= 1'b0;
    end
end
endmodule

// ==== hdl/dscr_regs.v ====
// shared configuration and status register bank of the deserializer
// assumes: one-cycle reg_wr/reg_rd strobes from the control bus slave
// Operation
// (RL1) parity check enable bit one, default set
// (RL2) checksum-valid status at bit seven
// (RL3) init-done status at bit six
// (RL4) latched self-test status follows pass pin
// (RL5) latched link status follows lock pin
// (RL6) sixteen-bit parity threshold from two bytes
// (RL7) per-port flag when errors reach threshold
// (RL8) abort channel transaction after programmed timeout
// (RL9) software never programs timeout value zero
// (RL10) watchdog stopped while disable bit set
// (RL11) block remote register writes when bit set
// (RL12) remote forwarding to far targets continues
// (RL13) rom reload bit restarts configuration load
// (RL14) latched bit clears on read if gone
// (RL15) counter clears when off; flag stays set
`timescale 1ns/1ps
`include "dscr_map.vh"
module dscr_regs
#(
    parameter TICK_CYC = `DSCR_TICK_CYC
)
(
    input wire clk,
    input wire rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_remote,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_q,
    input wire pass_pin,
    input wire lock_pin,
    input wire rom_done,
    input wire rom_cksum_ok,
    output reg rom_reload_q,
    input wire [1:0] parity_err,
    output reg [1:0] rx_port_status_one_q,
    input wire [1:0] status_clear,
    input wire cc_busy,
    output reg cc_abort_q,
    input wire remote_target_req,
    output reg remote_target_fwd_q
);
// ========================================
// registers
reg [7:0] gencfg_q;
reg [7:0] par_up_q;
reg [7:0] par_lo_q;
reg [7:0] ccto_q;
reg [7:0] busctl1_q;
reg pass_q;
reg lock_q;
reg init_done_q;
reg cksum_ok_q;
reg [31:0] tick_cnt_q;
reg [6:0] unit_cnt_q;
wire wr_ok;
wire [15:0] limit;
wire [1:0] hit;
wire tick;
wire [7:0] cond;

function sel;
    input [7:0] addr;
    input [7:0] want;
    begin
        sel = (addr == want);
    end
endfunction

// (RL11) remote writes dropped when blocked
assign wr_ok = reg_wr && !(reg_remote && busctl1_q[`DSCR_BIT_RWR_BLOCK]);
// (RL6) threshold from upper and lower bytes
assign limit = {par_up_q, par_lo_q};
assign cond = {cksum_ok_q, init_done_q, 2'b00, pass_q, lock_q, 2'b00};

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        gencfg_q <= `DSCR_RST_GENCFG;
        par_up_q <= `DSCR_RST_PAR_UP;
        par_lo_q <= `DSCR_RST_PAR_LO;
        ccto_q <= `DSCR_RST_CCTO;
        busctl1_q <= `DSCR_RST_BUSCTL1;
        rom_reload_q <= 1'b0;
    end
    else
    begin
        // (RL13) self-clearing reload pulse
        rom_reload_q <= wr_ok && sel(reg_addr, `DSCR_ADDR_RESET) && reg_wdata[`DSCR_BIT_RELOAD];
        if (wr_ok)
        begin
            // (RL1) enable held in general config
            if (sel(reg_addr, `DSCR_ADDR_GENCFG))
                gencfg_q <= reg_wdata;
            if (sel(reg_addr, `DSCR_ADDR_PAR_UP))
                par_up_q <= reg_wdata;
            if (sel(reg_addr, `DSCR_ADDR_PAR_LO))
                par_lo_q <= reg_wdata;
            if (sel(reg_addr, `DSCR_ADDR_CCTO))
                ccto_q <= reg_wdata;
            if (sel(reg_addr, `DSCR_ADDR_BUSCTL1))
                busctl1_q <= reg_wdata;
        end
    end
end

// ========================================
// status capture
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        pass_q <= 1'b0;
        lock_q <= 1'b0;
        init_done_q <= 1'b0;
        cksum_ok_q <= 1'b0;
    end
    else
    begin
        // (RL3) init done, cleared by reload
        if (rom_reload_q)
            init_done_q <= 1'b0;
        else if (rom_done)
            init_done_q <= 1'b1;
        // (RL2) checksum captured at init end
        if (rom_reload_q)
            cksum_ok_q <= 1'b0;
        else if (rom_done)
            cksum_ok_q <= rom_cksum_ok;
        // (RL4) pass latched high
        // (RL14) read clears only if gone
        if (pass_pin)
            pass_q <= 1'b1;
        else if (reg_rd && sel(reg_addr, `DSCR_ADDR_DEVCOND))
            pass_q <= 1'b0;
        // (RL5) lock latched high
        if (lock_pin)
            lock_q <= 1'b1;
        else if (reg_rd && sel(reg_addr, `DSCR_ADDR_DEVCOND))
            lock_q <= 1'b0;
    end
end

// ========================================
// parity monitors
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_port
        dscr_parity_mon u_mon
        (
            .clk(clk),
            .rst(rst),
            .enable(gencfg_q[`DSCR_BIT_PAR_EN]),
            .parity_err(parity_err[gi]),
            .limit(limit),
            .flag_clear(status_clear[gi]),
            .limit_hit_q(hit[gi])
        );
    end
endgenerate

// ========================================
// control channel watchdog
// whole-tick granularity; every unit is a full 2 ms tick, counting from zero when busy starts
assign tick = (tick_cnt_q == TICK_CYC - 1);
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        tick_cnt_q <= 32'h00000000;
        unit_cnt_q <= 7'h00;
        cc_abort_q <= 1'b0;
    end
    else
    begin
        cc_abort_q <= 1'b0;
        // (RL10) watchdog idle while disabled
        if (ccto_q[`DSCR_BIT_CCTO_OFF] || !cc_busy)
        begin
            tick_cnt_q <= 32'h00000000;
            unit_cnt_q <= 7'h00;
        end
        else
        begin
            tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
            // (RL8) abort after timeout units
            // (RL9) zero timeout aborts on first tick
            if (tick)
            begin
                if (unit_cnt_q + 7'h01 >= ccto_q[7:1])
                begin
                    cc_abort_q <= 1'b1;
                    unit_cnt_q <= 7'h00;
                end
                else
                    unit_cnt_q <= unit_cnt_q + 7'h01;
            end
        end
    end
end

// ========================================
// read data and outputs
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        reg_rdata_q <= 8'h00;
        rx_port_status_one_q <= 2'b00;
        remote_target_fwd_q <= 1'b0;
    end
    else
    begin
        rx_port_status_one_q <= hit;
        // (RL12) forwarding ignores write block
        remote_target_fwd_q <= remote_target_req;
        if (reg_rd)
        begin
            case (reg_addr)
                `DSCR_ADDR_GENCFG: reg_rdata_q <= gencfg_q;
                `DSCR_ADDR_VERSION: reg_rdata_q <= `DSCR_VERSION_VAL;
                `DSCR_ADDR_DEVCOND: reg_rdata_q <= cond;
                `DSCR_ADDR_PAR_UP: reg_rdata_q <= par_up_q;
                `DSCR_ADDR_PAR_LO: reg_rdata_q <= par_lo_q;
                `DSCR_ADDR_CCTO: reg_rdata_q <= ccto_q;
                `DSCR_ADDR_BUSCTL1: reg_rdata_q <= busctl1_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end
end
endmodule

// ==== bench/dscr_regs_props.sv ====
// checker on the register bank ports
// assumes: bound to dscr_regs, ports matched by name
`timescale 1ns/1ps
module dscr_regs_props
(
    input wire clk,
    input wire rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_remote,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_q,
    input wire pass_pin,
    input wire lock_pin,
    input wire rom_reload_q,
    input wire [1:0] rx_port_status_one_q,
    input wire [1:0] status_clear,
    input wire cc_busy,
    input wire cc_abort_q,
    input wire remote_target_req,
    input wire remote_target_fwd_q
);
    // ======================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_pulse;
        rom_reload_q ##1 !rom_reload_q;
    endsequence
    // restart waits a full tick, so no abort right after one
    sequence s_quiet;
        !cc_abort_q [*8];
    endsequence
    a_reload_pulse: assert property (reg_wr && !reg_remote && reg_addr == 8'h01 && reg_wdata[2] |=> s_pulse)
        else $error("no reload pulse");
    a_abort_gap: assert property (cc_abort_q |=> s_quiet)
        else $error("abort too soon");
    a_abort_busy: assert property (cc_abort_q |-> $past(cc_busy))
        else $error("abort while idle");
    // port output lags the flag by one edge, so a clear shows two edges later
    a_flag_held: assert property (rx_port_status_one_q[0] && !status_clear[0] && !$past(status_clear[0])
        |=> rx_port_status_one_q[0])
        else $error("port flag lost");
    a_flag_held_b: assert property (rx_port_status_one_q[1] && !status_clear[1] && !$past(status_clear[1])
        |=> rx_port_status_one_q[1])
        else $error("port flag lost");
    a_lock_seen: assert property (reg_rd && reg_addr == 8'h04 && lock_pin && $past(lock_pin) && !$past(rst)
        |=> reg_rdata_q[2])
        else $error("lock bit low");
    a_pass_seen: assert property (reg_rd && reg_addr == 8'h04 && pass_pin && $past(pass_pin) && !$past(rst)
        |=> reg_rdata_q[3])
        else $error("pass bit low");
    a_fwd_echo: assert property (remote_target_req |=> remote_target_fwd_q)
        else $error("no forward");
endmodule
bind dscr_regs dscr_regs_props dscr_regs_props_inst (.*);

// ==== bench/test_dscr_regs.sv ====
// bench for the register bank: defaults, status, reload, parity, watchdog, write block
// assumes: watchdog unit cut to 10 cycles to keep the run short
`timescale 1ns/1ps
module test_dscr_regs;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg reg_wr = 1'b0, reg_rd = 1'b0, reg_remote = 1'b0, pass_pin = 1'b0, lock_pin = 1'b0;
    reg rom_done = 1'b0, rom_cksum_ok = 1'b0, cc_busy = 1'b0, remote_target_req = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg [1:0] parity_err = 2'h0, status_clear = 2'h0;
    wire [7:0] reg_rdata_q;
    wire [1:0] rx_port_status_one_q;
    wire rom_reload_q, cc_abort_q, remote_target_fwd_q;
    integer num_errors = 0, checks_done = 0, n;
    dscr_regs #(.TICK_CYC(10)) dscr_regs_inst
    (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_remote(reg_remote), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .pass_pin(pass_pin), .lock_pin(lock_pin),
        .rom_done(rom_done), .rom_cksum_ok(rom_cksum_ok), .rom_reload_q(rom_reload_q), .parity_err(parity_err),
        .rx_port_status_one_q(rx_port_status_one_q), .status_clear(status_clear), .cc_busy(cc_busy),
        .cc_abort_q(cc_abort_q), .remote_target_req(remote_target_req), .remote_target_fwd_q(remote_target_fwd_q)
    );
    initial forever #2.5 clk = ~clk;
    // ======================================
    // shared tasks
    task chk(input [7:0] id, input [7:0] e, input [7:0] g);
    begin
        checks_done = checks_done + 1;
        if (g !== e)
        begin
            num_errors = num_errors + 1;
            $display("wrong value item %h expected %h seen %h", id, e, g);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d, input r);
    begin
        @(negedge clk) {reg_wr, reg_remote, reg_addr, reg_wdata} = {1'b1, r, a, d};
        @(negedge clk) {reg_wr, reg_remote} = 2'b00;
    end
    endtask
    task rd(input [7:0] a, input [7:0] e);
    begin
        @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk) reg_rd = 1'b0;
        chk(a, e, reg_rdata_q);
    end
    endtask
    task rom_load(input ok);
    begin
        @(negedge clk) {rom_done, rom_cksum_ok} = {1'b1, ok};
        @(negedge clk) rom_done = 1'b0;
    end
    endtask
    task err_pulse;
    begin
        @(negedge clk) parity_err = 2'b11;
        @(negedge clk) parity_err = 2'b00;
    end
    endtask
    // ======================================
    // scenarios
    task t_defaults;
    begin
        rd(8'h02, 8'h1E);
        rd(8'h05, 8'h01);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'hFE);
        rd(8'h04, 8'h00);
    end
    endtask
    task t_status;
    begin
        rom_load(1'b1);
        {lock_pin, pass_pin} = 2'b11;
        rd(8'h04, 8'hCC);
        {lock_pin, pass_pin} = 2'b00;
        rd(8'h04, 8'hCC);
        rd(8'h04, 8'hC0);
    end
    endtask
    task t_reload;
    begin
        wr(8'h01, 8'h04, 1'b0);
        chk(8'h01, 8'h01, rom_reload_q);
        rd(8'h04, 8'h00);
        rom_load(1'b0);
        rd(8'h04, 8'h40);
    end
    endtask
    task t_parity;
    begin
        // lower byte first, so the threshold never passes through zero
        wr(8'h06, 8'h03, 1'b1);
        wr(8'h05, 8'h00, 1'b0);
        for (n = 0; n < 3; n = n + 1)
        begin
            chk(8'hA0, 8'h00, rx_port_status_one_q);
            err_pulse;
        end
        // flag sets one edge after the count, the port output one edge later
        repeat (2) @(negedge clk);
        chk(8'hA0, 8'h03, rx_port_status_one_q);
        // clearing while disabled: only the cleared port drops
        wr(8'h02, 8'h1C, 1'b0);
        @(negedge clk) status_clear = 2'b01;
        @(negedge clk) status_clear = 2'b00;
        wr(8'h02, 8'h1E, 1'b0);
        err_pulse;
        @(negedge clk);
        chk(8'hA1, 8'h02, rx_port_status_one_q);
    end
    endtask
    task t_watchdog;
    begin
        wr(8'h07, 8'h04, 1'b0);
        @(negedge clk) cc_busy = 1'b1;
        n = 0;
        while (cc_abort_q !== 1'b1 && n < 100)
        begin
            @(negedge clk) n = n + 1;
        end
        chk(8'hB0, 8'h01, n > 17 && n < 23);
        if (n == 100)
            final_report;
        wr(8'h07, 8'h05, 1'b0);
        for (n = 0; n < 60; n = n + 1)
            @(negedge clk) chk(8'hB1, 8'h00, cc_abort_q);
        cc_busy = 1'b0;
    end
    endtask
    task t_block;
    begin
        wr(8'h08, 8'h80, 1'b0);
        wr(8'h06, 8'h55, 1'b1);
        rd(8'h06, 8'h03);
        wr(8'h06, 8'h66, 1'b0);
        rd(8'h06, 8'h66);
        @(negedge clk) remote_target_req = 1'b1;
        @(negedge clk) remote_target_req = 1'b0;
        chk(8'hC0, 8'h01, remote_target_fwd_q);
    end
    endtask
    task final_report;
    begin
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_defaults;
        t_status;
        t_reload;
        t_parity;
        t_watchdog;
        t_block;
        final_report;
    end
endmodule
